//--- hw/asl_dev.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module asl_dev #(
  parameter int unsigned SAMPLE_CYC = asl_pkg::SAMPLE_PERIOD_CYC,
  parameter int unsigned RST_CYC = asl_pkg::RESET_CYC,
  // Arbitrary revision value
  parameter logic [2:0] REVISION = 3'h5
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register link
  asl_link_if.dev lk,
  // Converter side
  input wire logic [asl_pkg::LK_DW-1:0] adc_data_i,
  output logic sample_o,
  output logic busy_o,
  output logic protected_o,
  output logic [7:0] cfg_o
);
  import asl_pkg::*;

  // ****************************************
  // Parameter checks
  // ****************************************
  if (SAMPLE_CYC < 2 || SAMPLE_CYC > 65535) begin : g_chk_smp
    $error("SAMPLE_CYC out of range");
  end
  if (RST_CYC < 1 || RST_CYC > 65535) begin : g_chk_rst
    $error("RST_CYC out of range");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] rst_cnt;
    logic busy;
    logic [7:0] cfg;
    logic [7:0] chk_prev;
    logic prot;
    logic [1:0] ctl;
    logic [15:0] smp_cnt;
    logic smp;
    logic [LATCH_W-1:0] latched;
    logic seen;
    logic [LK_DW-1:0] rdata;
  } asl_dev_st_t;

  // Reset flag is set while held in reset
  localparam asl_dev_st_t ST_RST = '{
    rst_cnt: 16'h0000,
    busy: 1'b1,
    cfg: CONFIG_RESET,
    chk_prev: 8'h00,
    prot: 1'b0,
    ctl: 2'h0,
    smp_cnt: 16'h0000,
    smp: 1'b0,
    latched: 12'h000,
    seen: 1'b1,
    rdata: 16'h0000
  };

  asl_dev_st_t st;
  asl_dev_st_t next_st;
  logic wr_hit;
  logic rd_hit;
  logic adc_rd;
  logic crc_evt;
  logic crc_clr;
  logic crc_q;
  logic miss_evt;
  logic miss_clr;
  logic miss_q;
  logic [LK_DW-1:0] pri_val;
  logic [LK_DW-1:0] sec_val;

  // Cheap rotate-add checksum; any single-bit change moves it
  function automatic logic [7:0] asl_chk(input logic [7:0] v);
    logic [8:0] s;
    s = {1'b0, v} + {1'b0, v[3:0], v[7:4]};
    return s[7:0] ^ 8'h00;
  endfunction : asl_chk

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.smp = 1'b0;
    next_st.ctl = 2'h0;
    wr_hit = lk.wr & (lk.sel | lk.bcast);
    rd_hit = lk.rd & lk.sel;
    adc_rd = rd_hit & (lk.addr <= OFS_ADC_LAST);
    crc_evt = 1'b0;
    miss_evt = 1'b0;
    crc_clr = rd_hit & (lk.addr == OFS_PRI_STAT);
    miss_clr = rd_hit & (lk.addr == OFS_SEC_STAT);

    if (st.busy) begin
      if (st.rst_cnt == 16'(RST_CYC - 1)) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.rst_cnt = st.rst_cnt + 16'h0001;
      end
    end

    if (wr_hit) begin
      case (lk.addr)
        OFS_CONFIG: begin
          if (!st.prot) begin
            next_st.cfg = lk.wdata[7:0];
          end
        end
        OFS_KEY: begin
          if (lk.wdata[7:0] == KEY_LOCK) begin
            next_st.prot = 1'b1;
          end else if (lk.wdata[7:0] == KEY_UNLOCK) begin
            next_st.prot = 1'b0;
          end
        end
        OFS_ALIGN: begin
          next_st.ctl = lk.wdata[1:0];
        end
        default: begin
        end
      endcase
    end

    next_st.chk_prev = asl_chk(st.cfg);
    crc_evt = asl_chk(st.cfg) != st.chk_prev;

    if (adc_rd) begin
      next_st.seen = 1'b1;
    end
    if (st.ctl[AL_ALIGN_BIT]) begin
      next_st.smp_cnt = 16'h0000;
    end else if (st.smp_cnt == 16'(SAMPLE_CYC - 1)) begin
      next_st.smp_cnt = 16'h0000;
      next_st.smp = 1'b1;
      miss_evt = !(st.seen | adc_rd);
      next_st.seen = 1'b0;
    end else begin
      next_st.smp_cnt = st.smp_cnt + 16'h0001;
    end
    if (st.ctl[AL_LATCH_BIT]) begin
      next_st.latched = st.smp_cnt[LATCH_W-1:0];
    end

    pri_val = '0;
    pri_val[PS_RESET_BIT] = st.busy;
    pri_val[PS_CRC_BIT] = crc_q;
    pri_val[PS_PROT_BIT] = st.prot;
    sec_val = '0;
    sec_val[2:0] = REVISION;
    sec_val[SS_MISSED_BIT] = miss_q;

    if (rd_hit) begin
      case (lk.addr)
        OFS_LATCHED: begin
          next_st.rdata = {{(LK_DW - LATCH_W){1'b0}}, st.latched};
        end
        OFS_CONFIG: begin
          next_st.rdata = {8'h00, st.cfg};
        end
        OFS_PRI_STAT: begin
          next_st.rdata = pri_val;
        end
        OFS_KEY: begin
          next_st.rdata = KEY_READ_VAL;
        end
        OFS_ALIGN: begin
          next_st.rdata = {14'h0000, st.ctl};
        end
        OFS_SEC_STAT: begin
          next_st.rdata = sec_val;
        end
        default: begin
          next_st.rdata = adc_rd ? adc_data_i : 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Sticky status flags
  // ****************************************
  asl_sticky_flag u_crc_flag (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .set_i(crc_evt),
    .clr_i(crc_clr),
    .flag_o(crc_q)
  );

  asl_sticky_flag u_miss_flag (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .set_i(miss_evt),
    .clr_i(miss_clr),
    .flag_o(miss_q)
  );

  assign lk.rdata = st.rdata;
  assign sample_o = st.smp;
  assign busy_o = st.busy;
  assign protected_o = st.prot;
  assign cfg_o = st.cfg;
endmodule : asl_dev

//--- hw/asl_pkg.sv
// Functional notes
// - Reset flag reads one during reset
// - Reset flag clears once ready for configuration
// - Checksum change sets checksum-changed flag
// - Protected flag at bit 2 mirrors lock
// - Key 0xCA locks configuration registers
// - Key 0x9C unlocks configuration registers
// - Key register write-only, reads 0x00
// - Broadcast align bit aligns next output instant
// - Align and latch bits self-clear after one cycle
// - Broadcast latch bit captures sample-timing counter
// - Unread sample within one period sets missed flag
// - Reading secondary status clears missed flag
// - Secondary status bits 2:0 show revision
// - Reserved bits read as zero
// - Latched counter register holds last capture
package asl_pkg;

  // ****************************************
  // Link geometry and device map
  // ****************************************
  localparam int LK_AW = 5;
  localparam int LK_DW = 16;
  localparam logic [4:0] OFS_ADC_LAST = 5'h06;
  localparam logic [4:0] OFS_LATCHED = 5'h07;
  localparam logic [4:0] OFS_CONFIG = 5'h08;
  localparam logic [4:0] OFS_PRI_STAT = 5'h09;
  localparam logic [4:0] OFS_KEY = 5'h0a;
  localparam logic [4:0] OFS_ALIGN = 5'h0b;
  localparam logic [4:0] OFS_SEC_STAT = 5'h0f;

  localparam int PS_RESET_BIT = 0;
  localparam int PS_CRC_BIT = 1;
  localparam int PS_PROT_BIT = 2;
  localparam int AL_ALIGN_BIT = 0;
  localparam int AL_LATCH_BIT = 1;
  localparam int SS_MISSED_BIT = 3;
  localparam int LATCH_W = 12;

  localparam logic [7:0] KEY_LOCK = 8'hca;
  localparam logic [7:0] KEY_UNLOCK = 8'h9c;
  localparam logic [15:0] KEY_READ_VAL = 16'h0000;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int SAMPLE_PERIOD_NS = 125000;
  localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RESET_TIME_NS = 1000;
  localparam int RESET_CYC =
    (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Host controller registers
  // ****************************************
  localparam int HOST_AW = 3;
  localparam logic [2:0] H_OFS_CMD = 3'h0;
  localparam logic [2:0] H_OFS_DATA = 3'h1;
  localparam logic [2:0] H_OFS_STAT = 3'h2;
  localparam logic [2:0] H_OFS_IRQ_STAT = 3'h3;
  localparam logic [2:0] H_OFS_IRQ_MASK = 3'h4;
  localparam int CMD_WRITE_BIT = 8;
  localparam int CMD_BCAST_BIT = 9;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_MISSED_BIT = 1;
  localparam int IRQ_W = 2;

  typedef enum logic [1:0] {
    ASL_H_IDLE,
    ASL_H_ISSUE,
    ASL_H_WAIT
  } asl_hphase_t;

endpackage : asl_pkg

//--- hw/asl_link_if.sv
`timescale 1ns/1ps
interface asl_link_if;
  logic sel;
  logic bcast;
  logic wr;
  logic rd;
  logic [asl_pkg::LK_AW-1:0] addr;
  logic [asl_pkg::LK_DW-1:0] wdata;
  logic [asl_pkg::LK_DW-1:0] rdata;

  modport dev (
    input sel, bcast, wr, rd, addr, wdata,
    output rdata
  );
  modport host (
    output sel, bcast, wr, rd, addr, wdata,
    input rdata
  );
endinterface : asl_link_if

//--- hw/asl_sticky_flag.sv
`timescale 1ns/1ps
module asl_sticky_flag (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Event and clear
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  typedef struct packed {
    logic flag;
  } asl_flag_st_t;

  asl_flag_st_t st;
  asl_flag_st_t next_st;

  // Set beats a clear arriving in the same cycle
  always_comb begin
    next_st = st;
    if (set_i) begin
      next_st.flag = 1'b1;
    end else if (clr_i) begin
      next_st.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag_o = st.flag;
endmodule : asl_sticky_flag

//--- hw/asl_host.sv
`timescale 1ns/1ps
module asl_host (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Software register port
  input wire logic [asl_pkg::HOST_AW-1:0] hst_addr_i,
  input wire logic [asl_pkg::LK_DW-1:0] hst_wdata_i,
  input wire logic hst_wr_i,
  input wire logic hst_rd_i,
  output logic [asl_pkg::LK_DW-1:0] hst_rdata_o,
  output logic irq_o,
  // Device link
  asl_link_if.host lk
);
  import asl_pkg::*;

  typedef struct packed {
    asl_hphase_t ph;
    logic sel;
    logic bcast;
    logic wr;
    logic rd;
    logic op_rd;
    logic [LK_AW-1:0] addr;
    logic [LK_DW-1:0] wdata;
    logic [LK_DW-1:0] data;
    logic [LK_DW-1:0] rdata;
    logic [IRQ_W-1:0] mask;
    logic irq;
  } asl_host_st_t;

  asl_host_st_t st;
  asl_host_st_t next_st;
  logic [IRQ_W-1:0] evt;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] flags;
  logic cmd_go;

  always_comb begin
    next_st = st;
    evt = '0;
    clr = '0;
    cmd_go = hst_wr_i & (hst_addr_i == H_OFS_CMD) & (st.ph == ASL_H_IDLE);

    case (st.ph)
      ASL_H_IDLE: begin
        if (cmd_go) begin
          next_st.ph = ASL_H_ISSUE;
          next_st.addr = hst_wdata_i[LK_AW-1:0];
          next_st.wdata = st.data;
          next_st.wr = hst_wdata_i[CMD_WRITE_BIT];
          next_st.rd = !hst_wdata_i[CMD_WRITE_BIT];
          next_st.op_rd = !hst_wdata_i[CMD_WRITE_BIT];
          next_st.bcast = hst_wdata_i[CMD_WRITE_BIT] &
                          hst_wdata_i[CMD_BCAST_BIT];
          next_st.sel = !(hst_wdata_i[CMD_WRITE_BIT] &
                          hst_wdata_i[CMD_BCAST_BIT]);
        end
      end
      ASL_H_ISSUE: begin
        next_st.ph = ASL_H_WAIT;
        next_st.sel = 1'b0;
        next_st.bcast = 1'b0;
        next_st.wr = 1'b0;
        next_st.rd = 1'b0;
      end
      ASL_H_WAIT: begin
        next_st.ph = ASL_H_IDLE;
        evt[IRQ_DONE_BIT] = 1'b1;
        if (st.op_rd) begin
          next_st.data = lk.rdata;
          evt[IRQ_MISSED_BIT] = (st.addr == OFS_SEC_STAT) &
                                lk.rdata[SS_MISSED_BIT];
        end
      end
      default: begin
        next_st.ph = ASL_H_IDLE;
      end
    endcase

    // Data writes are refused mid-transfer to keep the payload stable
    if (hst_wr_i) begin
      case (hst_addr_i)
        H_OFS_DATA: begin
          if (st.ph == ASL_H_IDLE) begin
            next_st.data = hst_wdata_i;
          end
        end
        H_OFS_IRQ_STAT: begin
          clr = hst_wdata_i[IRQ_W-1:0];
        end
        H_OFS_IRQ_MASK: begin
          next_st.mask = hst_wdata_i[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    if (hst_rd_i) begin
      case (hst_addr_i)
        H_OFS_DATA: begin
          next_st.rdata = st.data;
        end
        H_OFS_STAT: begin
          next_st.rdata = {15'h0000, st.ph != ASL_H_IDLE};
        end
        H_OFS_IRQ_STAT: begin
          next_st.rdata = {14'h0000, flags};
        end
        H_OFS_IRQ_MASK: begin
          next_st.rdata = {14'h0000, st.mask};
        end
        default: begin
          next_st.rdata = 16'h0000;
        end
      endcase
    end

    // Registered, so it trails the status bit by one cycle
    next_st.irq = |(flags & st.mask);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
    asl_sticky_flag u_flag (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .set_i(evt[i]),
      .clr_i(clr[i]),
      .flag_o(flags[i])
    );
  end

  assign lk.sel = st.sel;
  assign lk.bcast = st.bcast;
  assign lk.wr = st.wr;
  assign lk.rd = st.rd;
  assign lk.addr = st.addr;
  assign lk.wdata = st.wdata;
  assign hst_rdata_o = st.rdata;
  assign irq_o = st.irq;
endmodule : asl_host

//--- dv/asl_link_asserts.sv
`timescale 1ns/1ps
module asl_link_asserts #(
  parameter int unsigned RST_CYC = asl_pkg::RESET_CYC,
  parameter logic [2:0] REVISION = 3'h5
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Link signals
  input wire logic sel,
  input wire logic bcast,
  input wire logic wr,
  input wire logic rd,
  input wire logic [asl_pkg::LK_AW-1:0] addr,
  input wire logic [asl_pkg::LK_DW-1:0] wdata,
  input wire logic [asl_pkg::LK_DW-1:0] rdata
);
  import asl_pkg::*;

  // ****************************************
  // Helper state
  // ****************************************
  logic prot_m;
  int unsigned cnt;
  // Read strobe and address packed so properties see sampled values
  logic [5:0] rd_a;

  assign rd_a = {rd && sel, addr};

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prot_m <= 1'b0;
      cnt <= 0;
    end else begin
      // Saturate so long runs never wrap back into the busy window
      if (cnt < 1000) begin
        cnt <= cnt + 1;
      end
      if (wr && (sel || bcast) && addr == OFS_KEY) begin
        if (wdata[7:0] == KEY_LOCK) begin
          prot_m <= 1'b1;
        end else if (wdata[7:0] == KEY_UNLOCK) begin
          prot_m <= 1'b0;
        end
      end
    end
  end

  function automatic logic rd_of(input logic [5:0] ra, input logic [4:0] a);
    return ra == {1'b1, a};
  endfunction : rd_of

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // ****************************************
  // Properties
  // ****************************************
  property p_key_rd;
    rd_of(rd_a, OFS_KEY) |=> rdata == KEY_READ_VAL;
  endproperty
  a_key_rd: assert property (p_key_rd)
    else $error("key register read not zero");

  property p_pri_rsvd;
    rd_of(rd_a, OFS_PRI_STAT) |=> rdata[15:3] == 13'h0000;
  endproperty
  a_pri_rsvd: assert property (p_pri_rsvd)
    else $error("primary status reserved bits set");

  property p_prot;
    rd_of(rd_a, OFS_PRI_STAT) |=> rdata[PS_PROT_BIT] == $past(prot_m);
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected flag disagrees with key history");

  property p_busy_on;
    rd_of(rd_a, OFS_PRI_STAT) && cnt + 1 < RST_CYC |=> rdata[PS_RESET_BIT];
  endproperty
  a_busy_on: assert property (p_busy_on)
    else $error("reset flag low during reset time");

  property p_busy_off;
    rd_of(rd_a, OFS_PRI_STAT) && cnt > RST_CYC |=> !rdata[PS_RESET_BIT];
  endproperty
  a_busy_off: assert property (p_busy_off)
    else $error("reset flag still high after reset time");

  property p_sec_rev;
    rd_of(rd_a, OFS_SEC_STAT)
      |=> rdata[2:0] == REVISION && rdata[15:4] == 12'h000;
  endproperty
  a_sec_rev: assert property (p_sec_rev)
    else $error("secondary status revision or reserved bits wrong");

  property p_align_clr;
    rd_of(rd_a, OFS_ALIGN)
      && !$past(wr && (sel || bcast) && addr == OFS_ALIGN)
      |=> rdata == 16'h0000;
  endproperty
  a_align_clr: assert property (p_align_clr)
    else $error("command bits did not self clear");

  property p_latch_w;
    rd_of(rd_a, OFS_LATCHED) |=> rdata[15:LATCH_W] == 4'h0;
  endproperty
  a_latch_w: assert property (p_latch_w)
    else $error("latched counter upper bits set");

  c_lock: cover property (wr && sel && addr == OFS_KEY
    && wdata[7:0] == KEY_LOCK);
  c_align: cover property (wr && bcast && addr == OFS_ALIGN);
  c_missed: cover property (rd_of(rd_a, OFS_SEC_STAT)
    ##1 rdata[SS_MISSED_BIT]);
endmodule : asl_link_asserts

//--- dv/tb_adc_status_lock_sync_regs.sv
`timescale 1ns/1ps
module tb_adc_status_lock_sync_regs;
  import asl_pkg::*;
  // Short counts keep the run brief
  localparam int SCYC = 50;
  localparam int RCYC = 4;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] haddr = 3'h0;
  logic [15:0] hwdata = 16'h0000;
  logic hwr = 1'b0;
  logic hrd = 1'b0;
  logic [15:0] hrdata;
  logic irq;
  logic [15:0] adc = 16'h1234;
  logic sample;
  logic busy;
  logic prot;
  logic [7:0] cfg;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int wr_cyc = 0;
  int t1;
  int l1;
  logic [15:0] r;

  asl_link_if lk_if ();
  asl_dev #(.SAMPLE_CYC(SCYC), .RST_CYC(RCYC)) asl_dev_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .lk(lk_if.dev),
    .adc_data_i(adc), .sample_o(sample), .busy_o(busy),
    .protected_o(prot), .cfg_o(cfg));
  asl_host asl_host_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hst_addr_i(haddr),
    .hst_wdata_i(hwdata), .hst_wr_i(hwr), .hst_rd_i(hrd),
    .hst_rdata_o(hrdata), .irq_o(irq), .lk(lk_if.host));
  asl_link_asserts #(.RST_CYC(RCYC), .REVISION(3'h5))
    asl_link_asserts_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sel(lk_if.sel),
    .bcast(lk_if.bcast), .wr(lk_if.wr), .rd(lk_if.rd), .addr(lk_if.addr),
    .wdata(lk_if.wdata), .rdata(lk_if.rdata));

  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (lk_if.wr === 1'b1) begin
      wr_cyc <= cyc;
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task end_of_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    haddr <= a;
    hwdata <= d;
    hwr <= 1'b1;
    @(posedge clk_sys_i);
    hwr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [2:0] a);
    @(posedge clk_sys_i);
    haddr <= a;
    hrd <= 1'b1;
    @(posedge clk_sys_i);
    hrd <= 1'b0;
    #1 r = hrdata;
  endtask : rd_reg

  // One device access through the host, result left in r
  task dev_op(input logic w, input logic bc, input logic [4:0] a,
              input logic [15:0] d);
    int n;
    n = 0;
    if (w) begin
      wr_reg(H_OFS_DATA, d);
    end
    wr_reg(H_OFS_CMD, {6'h00, bc, w, 3'h0, a});
    r = 16'h0001;
    while (r[0] !== 1'b0) begin
      n++;
      if (n > 30) begin
        mismatches++;
        end_of_test();
      end
      rd_reg(H_OFS_STAT);
    end
    rd_reg(H_OFS_DATA);
  endtask : dev_op

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    dev_op(1'b0, 1'b0, OFS_PRI_STAT, 16'h0000);
    chk("pri in reset", 16'h0001, r);
    dev_op(1'b0, 1'b0, OFS_PRI_STAT, 16'h0000);
    chk("pri ready", 16'h0000, r);
    chk("busy_o", 16'h0000, {15'h0000, busy});
  endtask : t_reset

  task t_lock;
    dev_op(1'b1, 1'b0, OFS_KEY, 16'h0055);
    dev_op(1'b0, 1'b0, OFS_PRI_STAT, 16'h0000);
    chk("pri odd key", 16'h0000, r);
    dev_op(1'b1, 1'b0, OFS_KEY, {8'h00, KEY_LOCK});
    dev_op(1'b0, 1'b0, OFS_PRI_STAT, 16'h0000);
    chk("pri locked", 16'h0004, r);
    chk("protected_o", 16'h0001, {15'h0000, prot});
    dev_op(1'b1, 1'b0, OFS_CONFIG, 16'h003c);
    dev_op(1'b0, 1'b0, OFS_CONFIG, 16'h0000);
    chk("cfg locked", 16'h0000, r);
    chk("cfg_o locked", 16'h0000, {8'h00, cfg});
    dev_op(1'b0, 1'b0, OFS_KEY, 16'h0000);
    chk("key read", KEY_READ_VAL, r);
    dev_op(1'b1, 1'b0, OFS_KEY, {8'h00, KEY_UNLOCK});
    dev_op(1'b1, 1'b0, OFS_CONFIG, 16'h003c);
    dev_op(1'b0, 1'b0, OFS_CONFIG, 16'h0000);
    chk("cfg unlocked", 16'h003c, r);
    chk("cfg_o unlocked", 16'h003c, {8'h00, cfg});
    dev_op(1'b0, 1'b0, OFS_PRI_STAT, 16'h0000);
    chk("pri checksum", 16'h0002, r);
    dev_op(1'b0, 1'b0, 5'h0c, 16'h0000);
    chk("unmapped dev", 16'h0000, r);
    rd_reg(3'h7);
    chk("unmapped host", 16'h0000, r);
    chk("irq masked", 16'h0000, {15'h0000, irq});
  endtask : t_lock

  task t_align;
    int n;
    dev_op(1'b1, 1'b1, OFS_ALIGN, 16'h0001);
    t1 = wr_cyc;
    dev_op(1'b0, 1'b0, OFS_ALIGN, 16'h0000);
    chk("align cleared", 16'h0000, r);
    for (n = 0; n < 3 * SCYC && !(sample === 1'b1 && cyc > t1 + 3); n++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (n >= 3 * SCYC) begin
      mismatches++;
      end_of_test();
    end
    chk("align gap", 16'h0001,
        {15'h0000, cyc - t1 >= SCYC - 1 && cyc - t1 <= SCYC + 4});
  endtask : t_align

  task t_latch;
    dev_op(1'b1, 1'b1, OFS_ALIGN, 16'h0002);
    t1 = wr_cyc;
    dev_op(1'b0, 1'b0, OFS_LATCHED, 16'h0000);
    l1 = int'(r);
    repeat (7) @(posedge clk_sys_i);
    dev_op(1'b1, 1'b1, OFS_ALIGN, 16'h0002);
    l1 = (l1 + wr_cyc - t1) % SCYC;
    dev_op(1'b0, 1'b0, OFS_LATCHED, 16'h0000);
    chk("latched", l1[15:0], r);
  endtask : t_latch

  task t_missed;
    wr_reg(H_OFS_IRQ_MASK, 16'h0002);
    rd_reg(H_OFS_IRQ_MASK);
    chk("irq mask", 16'h0002, r);
    wr_reg(H_OFS_IRQ_STAT, 16'h0003);
    dev_op(1'b0, 1'b0, 5'h00, 16'h0000);
    dev_op(1'b0, 1'b0, OFS_SEC_STAT, 16'h0000);
    repeat (2 * SCYC + 10) @(posedge clk_sys_i);
    adc <= 16'hbeef;
    dev_op(1'b0, 1'b0, 5'h00, 16'h0000);
    chk("adc", 16'hbeef, r);
    dev_op(1'b0, 1'b0, OFS_SEC_STAT, 16'h0000);
    chk("sec missed", 16'h000d, r);
    repeat (3) @(posedge clk_sys_i);
    chk("irq set", 16'h0001, {15'h0000, irq});
    dev_op(1'b0, 1'b0, OFS_SEC_STAT, 16'h0000);
    chk("sec cleared", 16'h0005, r);
    wr_reg(H_OFS_IRQ_STAT, 16'h0003);
    repeat (3) @(posedge clk_sys_i);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
  endtask : t_missed

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_lock();
    t_align();
    t_latch();
    t_missed();
    end_of_test();
  end
endmodule : tb_adc_status_lock_sync_regs
